// >>> common/rcb_pkg.sv
// Purpose: constants for the ring cadence, relay and line bias register group
// Assumes: 200 MHz system clock, byte-wide internal register port
// Notes:
// How it works
// R1: silence timer is 16 bits, bytes 26/27
// R2: each silence count unit is 1.25 us
// R3: silence timer low byte resets to zero
// R4: silence timer used only when enable set
// R5: bursts alternate with reloaded silent intervals
// R6: relay config bits 7:6 read binary 10
// R7: bit 5 reports battery switch pin level
// R8: bit 4 flags third ringing rail present
// R9: bit 3 enables the relay driver output
// R10: bit 2 drives the general purpose pin
// R11: standby bit manual until next hook change
// R12: squelch shown, overridden until next speedup
// R13: cap bypass shown, overridden until next speedup
// R14: bias-on manual until next hook change
// R15: bits 3:2 pick on-hook bias 4-16 mA
// R16: bits 1:0 pick active bias 4-16 mA
package rcb_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] RCB_ADDR_RELAY = 8'h05; // relay_battery_config
  localparam logic [7:0] RCB_ADDR_BIAS = 8'h08; // line_bias_control
  localparam logic [7:0] RCB_ADDR_SIL_LO = 8'h1A; // ring_silence_timer_low
  localparam logic [7:0] RCB_ADDR_SIL_HI = 8'h1B; // ring_silence_timer_high
  // ==========================================================
  // field positions
  localparam int RCB_RLY_FIXED_HI = 7;
  localparam int RCB_RLY_FIXED_LO = 6;
  localparam logic [1:0] RCB_RLY_FIXED_VAL = 2'h2; // binary 10
  localparam int RCB_RLY_BATSW = 5;
  localparam int RCB_RLY_RAIL = 4;
  localparam int RCB_RLY_RELAY_DRIVER_OUT_EN = 3;
  localparam int RCB_RLY_GPO = 2;
  localparam int RCB_BIAS_LOW_POWER_STANDBY = 7;
  localparam int RCB_BIAS_MUTE = 6;
  localparam int RCB_BIAS_FILTER_CAP_BYPASS = 5;
  localparam int RCB_BIAS_ON = 4;
  localparam int RCB_BIAS_OLVL_HI = 3;
  localparam int RCB_BIAS_OLVL_LO = 2;
  localparam int RCB_BIAS_ALVL_HI = 1;
  localparam int RCB_BIAS_ALVL_LO = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0] RCB_RST_BYTE = 8'h00;
  localparam logic [1:0] RCB_RST_LVL = 2'h0;
  // ==========================================================
  // timing
  localparam int RCB_CLK_MHZ = 200;
  localparam int RCB_SIL_UNIT_NS_X100 = 125000; // 1.25 us in ns*100
  localparam int RCB_SIL_UNIT_CYC = (RCB_SIL_UNIT_NS_X100 * RCB_CLK_MHZ) / 100000;
  localparam logic [7:0] RCB_PRE_LAST = 8'(RCB_SIL_UNIT_CYC - 1);
  // ==========================================================
  // cadence states, one-hot
  typedef enum logic [2:0] {
    RCB_ST_IDLE = 3'h1,
    RCB_ST_RING = 3'h2,
    RCB_ST_QUIET = 3'h4
  } rcb_cad_t;
endpackage : rcb_pkg

// >>> logic/rcb_cadence.sv
// Purpose: alternates ringing bursts with timed silent gaps
// Assumes: burst_end_in is a one-cycle pulse from the active timer
// Notes: silence count reloaded at every burst end seen in the ring state while ring_req_in and both timer enables are set
`timescale 1ns/10ps
module rcb_cadence import rcb_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ring_req_in, // ringing oscillator requested
  input wire logic active_timer_en_in, // active timer enable
  input wire logic silence_timer_enable_in, // inactive timer enable
  input wire logic burst_end_in, // active interval expired
  input wire logic [15:0] ring_silence_count_in, // gap length in 1.25 us units
  output logic ring_on_out // ringing burst in progress
);
  // ==========================================================
  // state
  rcb_cad_t state_q;
  logic [15:0] remain_q; // silence units left
  logic [7:0] pre_q; // cycles within one unit
  logic unit_tick; // one unit elapsed
  logic cad_on;

  assign unit_tick = (pre_q == RCB_PRE_LAST); // R2
  assign cad_on = active_timer_en_in & silence_timer_enable_in;

  // prescaler, free during quiet only so each gap starts aligned
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q <= 8'h00;
    end else if (state_q != RCB_ST_QUIET || unit_tick) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // burst / gap sequencer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= RCB_ST_IDLE;
      remain_q <= 16'h0000;
    end else if (!ring_req_in) begin
      state_q <= RCB_ST_IDLE; // ringing withdrawn
    end else begin
      case (state_q)
        RCB_ST_IDLE: begin
          state_q <= RCB_ST_RING;
        end
        RCB_ST_RING: begin
          if (burst_end_in && cad_on) begin // R4
            state_q <= RCB_ST_QUIET; // R5
            remain_q <= ring_silence_count_in; // R1
          end
        end
        RCB_ST_QUIET: begin
          if (!cad_on || remain_q == 16'h0000) begin
            state_q <= RCB_ST_RING; // R5
          end else if (unit_tick) begin
            remain_q <= remain_q - 16'h0001; // R2
          end
        end
        default: begin
          state_q <= RCB_ST_IDLE;
        end
      endcase
    end
  end

  // registered burst flag
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ring_on_out <= 1'b0;
    end else begin
      ring_on_out <= ring_req_in && (state_q == RCB_ST_RING);
    end
  end
endmodule : rcb_cadence

// >>> logic/rcb_regs.sv
// Purpose: relay, bias and silence timer registers of one line channel
// Assumes: byte register port already decoded from the serial control port
// Notes: manual overrides on bias bits expire on hook or speedup events
`timescale 1ns/10ps
module rcb_regs import rcb_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in, // register address
  input wire logic reg_wr_in, // write strobe
  input wire logic [7:0] reg_wdata_in, // write data
  input wire logic reg_rd_in, // read strobe
  input wire logic battery_switch_pin_in, // level on battery select pin
  input wire logic hook_state_in, // 1 = off-hook
  input wire logic speedup_active_in, // speedup settling window
  input wire logic ring_req_in, // ringing requested
  input wire logic active_timer_en_in, // active timer enable
  input wire logic silence_timer_enable_in, // ring config bit 3
  input wire logic burst_end_in, // active interval ended, pulse
  output logic [7:0] reg_rdata_out, // read data, one cycle after strobe
  output logic relay_driver_out_en_out,
  output logic general_purpose_out_out,
  output logic third_rail_present_out,
  output logic low_power_standby_out,
  output logic audio_mute_ctrl_out,
  output logic filter_cap_bypass_out,
  output logic line_bias_on_out,
  output logic [1:0] onhook_bias_level_out,
  output logic [1:0] active_bias_level_out,
  output logic ring_on_out
);
  // ==========================================================
  // decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  logic wr_relay, wr_bias, wr_lo, wr_hi;
  assign wr_relay = reg_wr_in && hit(reg_addr_in, RCB_ADDR_RELAY);
  assign wr_bias = reg_wr_in && hit(reg_addr_in, RCB_ADDR_BIAS);
  assign wr_lo = reg_wr_in && hit(reg_addr_in, RCB_ADDR_SIL_LO);
  assign wr_hi = reg_wr_in && hit(reg_addr_in, RCB_ADDR_SIL_HI);

  // ==========================================================
  // silence timer bytes
  logic [7:0] sil_lo_q, sil_hi_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sil_lo_q <= RCB_RST_BYTE; // R3
      sil_hi_q <= RCB_RST_BYTE;
    end else begin
      if (wr_lo) begin
        sil_lo_q <= reg_wdata_in; // R1
      end
      if (wr_hi) begin
        sil_hi_q <= reg_wdata_in; // R1
      end
    end
  end

  // ==========================================================
  // relay configuration
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      third_rail_present_out <= 1'b0;
      relay_driver_out_en_out <= 1'b0;
      general_purpose_out_out <= 1'b0;
    end else if (wr_relay) begin
      third_rail_present_out <= reg_wdata_in[RCB_RLY_RAIL]; // R8
      relay_driver_out_en_out <= reg_wdata_in[RCB_RLY_RELAY_DRIVER_OUT_EN]; // R9
      general_purpose_out_out <= reg_wdata_in[RCB_RLY_GPO]; // R10
    end
  end

  // ==========================================================
  // bias event detection
  logic hook_prev_q, spd_prev_q;
  logic hook_evt, spd_evt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hook_prev_q <= 1'b0;
      spd_prev_q <= 1'b0;
    end else begin
      hook_prev_q <= hook_state_in;
      spd_prev_q <= speedup_active_in;
    end
  end

  assign hook_evt = hook_state_in ^ hook_prev_q; // either hook transition
  assign spd_evt = speedup_active_in & ~spd_prev_q; // new speedup window

  // ==========================================================
  // manual override flags; a write in the event cycle wins
  logic man_low_power_standby_q, man_mute_q, man_filter_cap_bypass_q, man_bias_q;
  logic val_low_power_standby_q, val_mute_q, val_filter_cap_bypass_q, val_bias_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      man_low_power_standby_q <= 1'b0;
      man_bias_q <= 1'b0;
      val_low_power_standby_q <= 1'b0;
      val_bias_q <= 1'b0;
    end else if (wr_bias) begin
      man_low_power_standby_q <= 1'b1; // R11
      man_bias_q <= 1'b1; // R14
      val_low_power_standby_q <= reg_wdata_in[RCB_BIAS_LOW_POWER_STANDBY];
      val_bias_q <= reg_wdata_in[RCB_BIAS_ON];
    end else if (hook_evt) begin
      man_low_power_standby_q <= 1'b0; // R11
      man_bias_q <= 1'b0; // R14
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      man_mute_q <= 1'b0;
      man_filter_cap_bypass_q <= 1'b0;
      val_mute_q <= 1'b0;
      val_filter_cap_bypass_q <= 1'b0;
    end else if (wr_bias) begin
      man_mute_q <= 1'b1; // R12
      man_filter_cap_bypass_q <= 1'b1; // R13
      val_mute_q <= reg_wdata_in[RCB_BIAS_MUTE];
      val_filter_cap_bypass_q <= reg_wdata_in[RCB_BIAS_FILTER_CAP_BYPASS];
    end else if (spd_evt) begin
      man_mute_q <= 1'b0; // R12
      man_filter_cap_bypass_q <= 1'b0; // R13
    end
  end

  // ==========================================================
  // bias level fields
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      onhook_bias_level_out <= RCB_RST_LVL;
      active_bias_level_out <= RCB_RST_LVL;
    end else if (wr_bias) begin
      onhook_bias_level_out <= reg_wdata_in[RCB_BIAS_OLVL_HI:RCB_BIAS_OLVL_LO]; // R15
      active_bias_level_out <= reg_wdata_in[RCB_BIAS_ALVL_HI:RCB_BIAS_ALVL_LO]; // R16
    end
  end

  // ==========================================================
  // effective bias state: automatic unless overridden
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_power_standby_out <= 1'b0;
      line_bias_on_out <= 1'b0;
      audio_mute_ctrl_out <= 1'b0;
      filter_cap_bypass_out <= 1'b0;
    end else begin
      // on-hook means standby, off-hook means bias on
      low_power_standby_out <= man_low_power_standby_q ? val_low_power_standby_q : ~hook_state_in; // R11
      line_bias_on_out <= man_bias_q ? val_bias_q : hook_state_in; // R14
      audio_mute_ctrl_out <= man_mute_q ? val_mute_q : speedup_active_in; // R12
      filter_cap_bypass_out <= man_filter_cap_bypass_q ? val_filter_cap_bypass_q : speedup_active_in; // R13
    end
  end

  // ==========================================================
  // read mux, registered; unmapped reads return zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= RCB_RST_BYTE;
    end else if (reg_rd_in) begin
      reg_rdata_out <= RCB_RST_BYTE;
      if (hit(reg_addr_in, RCB_ADDR_RELAY)) begin
        reg_rdata_out[RCB_RLY_FIXED_HI:RCB_RLY_FIXED_LO] <= RCB_RLY_FIXED_VAL; // R6
        reg_rdata_out[RCB_RLY_BATSW] <= battery_switch_pin_in; // R7
        reg_rdata_out[RCB_RLY_RAIL] <= third_rail_present_out; // R8
        reg_rdata_out[RCB_RLY_RELAY_DRIVER_OUT_EN] <= relay_driver_out_en_out; // R9
        reg_rdata_out[RCB_RLY_GPO] <= general_purpose_out_out; // R10
      end else if (hit(reg_addr_in, RCB_ADDR_BIAS)) begin
        reg_rdata_out[RCB_BIAS_LOW_POWER_STANDBY] <= low_power_standby_out; // R11
        reg_rdata_out[RCB_BIAS_MUTE] <= audio_mute_ctrl_out; // R12
        reg_rdata_out[RCB_BIAS_FILTER_CAP_BYPASS] <= filter_cap_bypass_out; // R13
        reg_rdata_out[RCB_BIAS_ON] <= line_bias_on_out; // R14
        reg_rdata_out[RCB_BIAS_OLVL_HI:RCB_BIAS_OLVL_LO] <= onhook_bias_level_out;
        reg_rdata_out[RCB_BIAS_ALVL_HI:RCB_BIAS_ALVL_LO] <= active_bias_level_out;
      end else if (hit(reg_addr_in, RCB_ADDR_SIL_LO)) begin
        reg_rdata_out <= sil_lo_q; // R1
      end else if (hit(reg_addr_in, RCB_ADDR_SIL_HI)) begin
        reg_rdata_out <= sil_hi_q; // R1
      end
    end
  end

  // ==========================================================
  // cadence sequencer
  rcb_cadence i_rcb_cadence (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ring_req_in(ring_req_in),
    .active_timer_en_in(active_timer_en_in),
    .silence_timer_enable_in(silence_timer_enable_in),
    .burst_end_in(burst_end_in),
    .ring_silence_count_in({sil_hi_q, sil_lo_q}),
    .ring_on_out(ring_on_out)
  );
endmodule : rcb_regs

// >>> sim/rcb_regs_asserts.sv
// Purpose: port-level assertions for rcb_regs
// Assumes: one clock, async active-low reset
// Notes: bound to every rcb_regs instance
`timescale 1ns/10ps
module rcb_regs_asserts import rcb_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic battery_switch_pin_in,
  input wire logic hook_state_in,
  input wire logic speedup_active_in,
  input wire logic ring_req_in,
  input wire logic active_timer_en_in,
  input wire logic silence_timer_enable_in,
  input wire logic burst_end_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic relay_driver_out_en_out,
  input wire logic general_purpose_out_out,
  input wire logic third_rail_present_out,
  input wire logic low_power_standby_out,
  input wire logic audio_mute_ctrl_out,
  input wire logic filter_cap_bypass_out,
  input wire logic line_bias_on_out,
  input wire logic [1:0] onhook_bias_level_out,
  input wire logic [1:0] active_bias_level_out,
  input wire logic ring_on_out
);
  // ==========================================================
  // helpers
  logic bias_wr; // write to bias register
  logic rly_wr; // write to relay register
  assign bias_wr = reg_wr_in && (reg_addr_in == RCB_ADDR_BIAS);
  assign rly_wr = reg_wr_in && (reg_addr_in == RCB_ADDR_RELAY);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // hook change left alone for two cycles, so auto control is back
  sequence s_hook;
    ($changed(hook_state_in) && !bias_wr) ##1 (!bias_wr && $stable(hook_state_in))[*2];
  endsequence
  // speedup start with the window held open
  sequence s_spd;
    ($rose(speedup_active_in) && !bias_wr) ##1 (speedup_active_in && !bias_wr)[*2];
  endsequence
  // manual write with no hook event after it
  sequence s_man;
    bias_wr ##1 (!bias_wr && $stable(hook_state_in))[*3];
  endsequence
  // ==========================================================
  // checks
  chk_relay_follow: assert property (rly_wr |=> {third_rail_present_out,
    relay_driver_out_en_out, general_purpose_out_out} == $past(reg_wdata_in[4:2]))
    else $error("relay outputs differ from write");
  // pin level is taken at the read edge, so compare against that edge's value
  chk_relay_read: assert property (reg_rd_in && reg_addr_in == RCB_ADDR_RELAY
    |=> reg_rdata_out[7:5] == {2'b10, $past(battery_switch_pin_in)}
    && reg_rdata_out[1:0] == 2'b00)
    else $error("relay readback fixed bits wrong");
  // level fields land one edge after the write, back-to-back writes allowed
  chk_onhook_lvl: assert property (bias_wr |=>
    onhook_bias_level_out == $past(reg_wdata_in[3:2]))
    else $error("on-hook level not applied");
  chk_active_lvl: assert property (bias_wr |=>
    active_bias_level_out == $past(reg_wdata_in[1:0]))
    else $error("active level not applied");
  chk_hook_auto: assert property (s_hook |->
    low_power_standby_out == !hook_state_in && line_bias_on_out == hook_state_in)
    else $error("hook change left manual bias");
  chk_manual_hold: assert property (s_man |->
    low_power_standby_out == $past(reg_wdata_in[7], 3))
    else $error("manual standby lost");
  chk_speedup_auto: assert property (s_spd |->
    audio_mute_ctrl_out && filter_cap_bypass_out)
    else $error("speedup did not restore auto");
  // the enable seen by the sequencer is the one of the previous edge
  chk_no_gap_off: assert property (ring_on_out && ring_req_in
    && !$past(silence_timer_enable_in) |=> ring_on_out)
    else $error("silence gap without enable");
endmodule : rcb_regs_asserts
bind rcb_regs rcb_regs_asserts i_rcb_regs_asserts (.*);

// >>> sim/test_rcb_regs.sv
// Purpose: directed register and cadence tests for rcb_regs
// Assumes: 200 MHz clock, inputs driven at falling edge
// Notes: gap tolerance of a few cycles covers pipeline delay
`timescale 1ns/10ps
module test_rcb_regs import rcb_pkg::*; ;
  logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic battery_switch_pin_in = 1'b0, hook_state_in = 1'b0, speedup_active_in = 1'b0;
  logic ring_req_in = 1'b0, active_timer_en_in = 1'b0, silence_timer_enable_in = 1'b0;
  logic burst_end_in = 1'b0, relay_driver_out_en_out, general_purpose_out_out;
  logic third_rail_present_out, low_power_standby_out, audio_mute_ctrl_out;
  logic filter_cap_bypass_out, line_bias_on_out, ring_on_out;
  logic [1:0] onhook_bias_level_out, active_bias_level_out;
  int err_total = 0, total_checks = 0, n;
  always #2.5 clk_in = ~clk_in; // 5 ns period
  rcb_regs i_rcb_regs (.*);
  // ==========================================================
  // tasks
  task results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in} = {1'b1, a, d};
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    {reg_rd_in, reg_addr_in} = {1'b1, a};
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    chk("read data", e, reg_rdata_out);
  endtask : rd
  task cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask : cyc
  // bounded wait for ring_on_out to reach a level
  task wait_ring(input logic lvl, input int lim);
    n = 0;
    while (ring_on_out !== lvl && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("Error ring wait expected %h seen %h", lvl, ring_on_out);
      results();
    end
  endtask : wait_ring
  task pulse_end;
    @(negedge clk_in);
    burst_end_in = 1'b1;
    @(negedge clk_in);
    burst_end_in = 1'b0;
  endtask : pulse_end
  // ==========================================================
  // main sequence
  initial begin
    cyc(5);
    rst_n_in = 1'b1;
    rd(RCB_ADDR_SIL_LO, 8'h00);
    rd(RCB_ADDR_RELAY, 8'h80);
    rd(8'h33, 8'h00);
    $display("test reset done");
    battery_switch_pin_in = 1'b1;
    wr(RCB_ADDR_RELAY, 8'hFF);
    rd(RCB_ADDR_RELAY, 8'hBC);
    chk("relay outs", 8'h07, {third_rail_present_out, relay_driver_out_en_out,
      general_purpose_out_out});
    wr(RCB_ADDR_RELAY, 8'h00);
    battery_switch_pin_in = 1'b0;
    rd(RCB_ADDR_RELAY, 8'h80);
    chk("relay outs", 8'h00, {third_rail_present_out, relay_driver_out_en_out,
      general_purpose_out_out});
    wr(RCB_ADDR_SIL_LO, 8'h5A);
    wr(RCB_ADDR_SIL_HI, 8'hC3);
    rd(RCB_ADDR_SIL_LO, 8'h5A);
    rd(RCB_ADDR_SIL_HI, 8'hC3);
    $display("test relay and timer done");
    for (int i = 0; i < 4; i++) begin
      wr(RCB_ADDR_BIAS, {4'h0, 2'(i), ~2'(i)});
      cyc(1);
      chk("bias levels", {4'h0, 2'(i), ~2'(i)},
        {4'h0, onhook_bias_level_out, active_bias_level_out});
    end
    wr(RCB_ADDR_BIAS, 8'h10); // manual: standby off, bias on, hook on
    cyc(2);
    chk("manual low_power_standby bias", 8'h01, {low_power_standby_out, line_bias_on_out});
    rd(RCB_ADDR_BIAS, 8'h10);
    hook_state_in = 1'b1;
    cyc(3);
    hook_state_in = 1'b0;
    cyc(3);
    chk("auto low_power_standby bias", 8'h02, {low_power_standby_out, line_bias_on_out});
    speedup_active_in = 1'b1;
    cyc(3);
    wr(RCB_ADDR_BIAS, 8'h00);
    cyc(2);
    chk("manual mute filter_cap_bypass", 8'h00, {audio_mute_ctrl_out, filter_cap_bypass_out});
    speedup_active_in = 1'b0;
    cyc(2);
    speedup_active_in = 1'b1;
    cyc(3);
    chk("auto mute filter_cap_bypass", 8'h03, {audio_mute_ctrl_out, filter_cap_bypass_out});
    rd(RCB_ADDR_BIAS, 8'h60);
    $display("test bias done");
    wr(RCB_ADDR_SIL_LO, 8'h02);
    wr(RCB_ADDR_SIL_HI, 8'h00);
    {active_timer_en_in, silence_timer_enable_in, ring_req_in} = 3'b111;
    wait_ring(1'b1, 10);
    pulse_end();
    cyc(2);
    chk("ring quiet", 8'h00, {7'h0, ring_on_out});
    wait_ring(1'b1, 600);
    chk("gap in range", 8'h01, {7'h0, n >= 490 && n <= 505});
    silence_timer_enable_in = 1'b0;
    pulse_end();
    cyc(3);
    chk("ring kept", 8'h01, {7'h0, ring_on_out});
    $display("test cadence done");
    // mid-run reset must clear the low timer byte again
    rst_n_in = 1'b0;
    cyc(2);
    rst_n_in = 1'b1;
    rd(RCB_ADDR_SIL_LO, 8'h00);
    $display("test second reset done");
    results();
  end
endmodule : test_rcb_regs
